/* File: rtl/wdsf_top.sv */
// watchdog service, interrupt status and core fault capture registers
// assumes a classic wishbone master and fault reports from core bus logic on mclk
//
// How it works
// [R1] service is 0x55 then 0xAA before time-out
// [R2] other accesses between service writes are allowed, except control writes
// [R3] writes after time-out keep irq, request no reset
// [R4] service register holds no state, reads zero
// [R5] bad service value resets while enabled and not timed out
// [R6] time-out irq modes set status bit 0
// [R7] status bit 0 clears on written one
// [R8] bus error sets status bit 1 always
// [R9] status bit 1 clears on written one
// [R10] fault irq is flag and enable
// [R11] stale flag raises irq on enable
// [R12] software clears stale flag before enabling
// [R13] fault captures address, attributes, write data
// [R14] fault address is read-only last fault
// [R15] enable bit 0 gates fault irq
// [R16] two-bit mode picks four responses
// [R17] period is two to n, n min 8
// [R18] watchdog disabled after reset
// [R19] control write restarts counter
// [R20] good service restarts counter, clears first half
// [R21] reserved bits read zero, ignore writes
//
// Implementation choices: the Wishbone slave port and the address map.
module wdsf_top (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [wdsf_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [wdsf_pkg::DAT_W-1:0] wb_dat_i,
  output logic [wdsf_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // core bus fault report
  input wire logic fault_valid,
  input wire logic [31:0] fault_addr,
  input wire logic fault_write,
  input wire logic [2:0] fault_size,
  input wire logic fault_cache,
  input wire logic fault_super,
  input wire logic fault_data,
  input wire logic [31:0] fault_wdata,
  // requests out
  output logic wdog_irq,
  output logic fault_irq,
  output logic sys_reset_req
);
  import wdsf_pkg::*;

  logic ack_r;
  logic [DAT_W-1:0] rdata_r;
  logic [15:0] ctrl_r;
  logic wdog_flag_r;
  logic fault_flag_r;
  logic fault_ien_r;
  logic fault_irq_r;
  logic wdog_flag_nxt;
  logic fault_flag_nxt;
  logic fault_ien_nxt;
  logic req;
  logic wr;
  logic ctrl_write;
  logic svc_write;
  logic stat_write;
  logic ien_write;
  logic irq_set;
  logic reset_req;
  logic [7:0] fault_attr;
  logic [31:0] cap_addr;
  logic [7:0] cap_attr;
  logic [31:0] cap_data;
  logic [DAT_W-1:0] rdata_nxt;

  always_comb begin
    req = wb_cyc_i && wb_stb_i;
    wr = req && wb_we_i && ack_r;
    ctrl_write = wr && wdsf_hit(wb_adr_i, OFF_WD_CTRL);
    svc_write = wr && wb_sel_i[0] && wdsf_hit(wb_adr_i, OFF_WD_SVC);
    stat_write = wr && wb_sel_i[0] && wdsf_hit(wb_adr_i, OFF_INT_STAT);
    ien_write = wr && wb_sel_i[0] && wdsf_hit(wb_adr_i, OFF_FLT_IEN);
    fault_attr = 8'h00;
    fault_attr[ATTR_WRITE_BIT] = fault_write;
    fault_attr[ATTR_SIZE_LSB +: 3] = fault_size;
    fault_attr[ATTR_CACHE_BIT] = fault_cache;
    fault_attr[ATTR_MODE_BIT] = fault_super;
    fault_attr[ATTR_TYPE_BIT] = fault_data;
  end

  // wishbone handshake, one wait state, write lands on the ack edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // read mux, unmapped and write-only offsets read zero
  always_comb begin
    rdata_nxt = '0;
    if (wdsf_hit(wb_adr_i, OFF_WD_CTRL)) begin
      rdata_nxt[15:0] = ctrl_r;
    end else if (wdsf_hit(wb_adr_i, OFF_WD_SVC)) begin
      rdata_nxt = '0; // [R4]
    end else if (wdsf_hit(wb_adr_i, OFF_INT_STAT)) begin
      rdata_nxt[STAT_WDOG_BIT] = wdog_flag_r; // [R21]
      rdata_nxt[STAT_FAULT_BIT] = fault_flag_r;
    end else if (wdsf_hit(wb_adr_i, OFF_FLT_ADDR)) begin
      rdata_nxt = cap_addr; // [R14]
    end else if (wdsf_hit(wb_adr_i, OFF_FLT_IEN)) begin
      rdata_nxt[IEN_FAULT_BIT] = fault_ien_r; // [R21]
    end else if (wdsf_hit(wb_adr_i, OFF_FLT_ATTR)) begin
      rdata_nxt[7:0] = cap_attr;
    end else if (wdsf_hit(wb_adr_i, OFF_FLT_DATA)) begin
      rdata_nxt = cap_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else if (req && !ack_r && !wb_we_i) begin
      rdata_r <= rdata_nxt;
    end else if (!req) begin
      rdata_r <= '0;
    end
  end

  // watchdog control, lock bit holds until reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET; // [R18]
    end else if (ctrl_write && !ctrl_r[CTRL_LOCK_BIT]) begin
      if (wb_sel_i[0]) begin
        ctrl_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_r[15:8] <= wb_dat_i[15:8] & CTRL_WMASK[15:8];
      end
    end
  end

  // status flags, set wins over clear
  always_comb begin
    wdog_flag_nxt = wdog_flag_r;
    fault_flag_nxt = fault_flag_r;
    fault_ien_nxt = fault_ien_r;
    if (stat_write && wb_dat_i[STAT_WDOG_BIT]) begin
      wdog_flag_nxt = 1'b0; // [R7]
    end
    if (stat_write && wb_dat_i[STAT_FAULT_BIT]) begin
      fault_flag_nxt = 1'b0; // [R9]
    end
    if (irq_set) begin
      wdog_flag_nxt = 1'b1; // [R6] [R3]
    end
    if (fault_valid) begin
      fault_flag_nxt = 1'b1; // [R8]
    end
    if (ien_write) begin
      fault_ien_nxt = wb_dat_i[IEN_FAULT_BIT]; // [R15] [R21]
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wdog_flag_r <= 1'b0;
      fault_flag_r <= 1'b0;
      fault_ien_r <= 1'b0;
      fault_irq_r <= 1'b0;
    end else begin
      wdog_flag_r <= wdog_flag_nxt;
      fault_flag_r <= fault_flag_nxt;
      fault_ien_r <= fault_ien_nxt;
      fault_irq_r <= fault_flag_nxt && fault_ien_nxt; // [R10] [R11]
    end
  end

  wdsf_wdog u_wdog (
    .mclk(mclk),
    .resetn(resetn),
    .enable(ctrl_r[CTRL_EN_BIT]),
    .mode(wdsf_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2])),
    .tmo_sel(ctrl_r[CTRL_TMO_LSB +: 5]),
    .ctrl_write(ctrl_write),
    .svc_write(svc_write),
    .svc_data(wb_dat_i[7:0]),
    .irq_set_r(irq_set),
    .reset_req_r(reset_req)
  );

  wdsf_fault_cap u_cap (
    .mclk(mclk),
    .resetn(resetn),
    .fault_valid(fault_valid),
    .fault_addr(fault_addr),
    .fault_attr(fault_attr),
    .fault_wdata(fault_wdata),
    .addr_r(cap_addr),
    .attr_r(cap_attr),
    .data_r(cap_data)
  );

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign wdog_irq = wdog_flag_r;
  assign fault_irq = fault_irq_r;
  assign sys_reset_req = reset_req;
endmodule // wdsf_top

/* File: common/wdsf_pkg.sv */
// constants, register map and field layout of the watchdog / fault status unit
// assumes a 32-bit classic wishbone slave port and a single 10 MHz clock
package wdsf_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int CLK_HZ = 10000000;

  // register byte offsets
  localparam logic [7:0] OFF_WD_CTRL = 8'h00;
  localparam logic [7:0] OFF_WD_SVC = 8'h04;
  localparam logic [7:0] OFF_INT_STAT = 8'h08;
  localparam logic [7:0] OFF_FLT_ADDR = 8'h0C;
  localparam logic [7:0] OFF_FLT_IEN = 8'h10;
  localparam logic [7:0] OFF_FLT_ATTR = 8'h14;
  localparam logic [7:0] OFF_FLT_DATA = 8'h18;

  // watchdog control fields
  localparam int CTRL_LOCK_BIT = 15;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_TMO_LSB = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h80FF;

  // interrupt status / enable fields
  localparam int STAT_WDOG_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int IEN_FAULT_BIT = 0;

  // fault attribute fields
  localparam int ATTR_WRITE_BIT = 7;
  localparam int ATTR_SIZE_LSB = 4;
  localparam int ATTR_CACHE_BIT = 3;
  localparam int ATTR_MODE_BIT = 1;
  localparam int ATTR_TYPE_BIT = 0;

  // service values and period limits
  localparam logic [7:0] SVC_FIRST = 8'h55;
  localparam logic [7:0] SVC_SECOND = 8'hAA;
  localparam logic [4:0] TMO_MIN = 5'h08;

  // time-out response modes
  typedef enum logic [1:0] {
    WDSF_MODE_IRQ = 2'h0,
    WDSF_MODE_IRQ_RST = 2'h1,
    WDSF_MODE_RST = 2'h2,
    WDSF_MODE_WINDOW = 2'h3
  } wdsf_mode_t;

  function automatic logic wdsf_hit(input logic [ADR_W-1:0] adr, input logic [7:0] off);
    wdsf_hit = ({adr[ADR_W-1:2], 2'h0} == off);
  endfunction
endpackage

/* File: rtl/wdsf_wdog.sv */
// watchdog counter, two-write service unlock and time-out responses
// assumes control fields and service writes come from the register block on mclk
module wdsf_wdog (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // configuration
  input wire logic enable,
  input wire wdsf_pkg::wdsf_mode_t mode,
  input wire logic [4:0] tmo_sel,
  input wire logic ctrl_write,
  // service writes
  input wire logic svc_write,
  input wire logic [7:0] svc_data,
  // responses
  output logic irq_set_r,
  output logic reset_req_r
);
  import wdsf_pkg::*;

  logic [31:0] count_r;
  logic armed_r;
  logic timed_out_r;
  logic [4:0] shift;
  logic [31:0] last;
  logic [31:0] window_start;
  logic expire;
  logic value_ok;
  logic good_pair;
  logic early;
  logic bad_write;

  always_comb begin
    shift = (tmo_sel < TMO_MIN) ? TMO_MIN : tmo_sel; // [R17]
    last = (32'h1 << shift) - 32'h1;
    window_start = last - (last >> 2);
    expire = enable && (count_r == last);
    value_ok = (svc_data == SVC_FIRST) || (svc_data == SVC_SECOND);
    good_pair = svc_write && armed_r && (svc_data == SVC_SECOND); // [R1]
    early = (mode == WDSF_MODE_WINDOW) && (count_r < window_start); // [R16]
    bad_write = svc_write && enable && !timed_out_r && (!value_ok || early); // [R5]
  end

  // counter
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count_r <= 32'h0;
    end else if (!enable || ctrl_write) begin // [R18] [R19]
      count_r <= 32'h0;
    end else if (good_pair && !early) begin // [R20]
      count_r <= 32'h0;
    end else if (expire) begin
      count_r <= 32'h0;
    end else begin
      count_r <= count_r + 32'h1;
    end
  end

  // service sequence, first half remembered across other accesses, cleared by control writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      armed_r <= 1'b0;
    end else if (ctrl_write || good_pair) begin // [R20]
      armed_r <= 1'b0;
    end else if (svc_write) begin // [R2]
      armed_r <= (svc_data == SVC_FIRST);
    end
  end

  // time-out state and responses
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      timed_out_r <= 1'b0;
      irq_set_r <= 1'b0;
      reset_req_r <= 1'b0;
    end else begin
      irq_set_r <= 1'b0;
      reset_req_r <= bad_write;
      if (!enable || ctrl_write) begin
        timed_out_r <= 1'b0;
      end else if (good_pair && !early) begin
        timed_out_r <= 1'b0;
      end
      if (expire && !(good_pair && !early)) begin
        unique case (mode)
          WDSF_MODE_IRQ: begin
            irq_set_r <= 1'b1; // [R6]
            timed_out_r <= 1'b1;
          end
          WDSF_MODE_IRQ_RST: begin
            if (timed_out_r) begin
              reset_req_r <= 1'b1;
            end else begin
              irq_set_r <= 1'b1;
              timed_out_r <= 1'b1;
            end
          end
          WDSF_MODE_RST: begin
            reset_req_r <= 1'b1;
          end
          WDSF_MODE_WINDOW: begin
            reset_req_r <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // wdsf_wdog

/* File: rtl/wdsf_fault_cap.sv */
// capture of address, attributes and write data of the last faulted core access
// assumes fault inputs are a one-cycle strobe with its data on mclk
module wdsf_fault_cap (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // faulted access
  input wire logic fault_valid,
  input wire logic [31:0] fault_addr,
  input wire logic [7:0] fault_attr,
  input wire logic [31:0] fault_wdata,
  // captured values
  output logic [31:0] addr_r,
  output logic [7:0] attr_r,
  output logic [31:0] data_r
);
  import wdsf_pkg::*;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      addr_r <= 32'h0;
      attr_r <= 8'h00;
    end else if (fault_valid) begin
      addr_r <= fault_addr; // [R13] [R14]
      attr_r <= fault_attr;
    end
  end

  // write data kept only for write faults
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      data_r <= 32'h0;
    end else if (fault_valid && fault_attr[ATTR_WRITE_BIT]) begin
      data_r <= fault_wdata; // [R13]
    end
  end
endmodule // wdsf_fault_cap

/* File: test/wdsf_props.sv */
// checker of the unit's bus answer, flags and requests
// assumes wdsf_pkg is compiled first; bound into wdsf_top
module wdsf_props (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [wdsf_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [wdsf_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [wdsf_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // requests
  input wire logic fault_valid,
  input wire logic wdog_irq,
  input wire logic fault_irq,
  input wire logic sys_reset_req
);
  import wdsf_pkg::*;
  logic wr, rd, st, armed_r;
  assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign rd = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;
  assign st = wdsf_hit(wb_adr_i, OFF_INT_STAT);
  // set once software turns the watchdog on
  always_ff @(posedge mclk) begin
    if (!resetn)
      armed_r <= 1'b0;
    else if (wr && wdsf_hit(wb_adr_i, OFF_WD_CTRL) && wb_dat_i[CTRL_EN_BIT])
      armed_r <= 1'b1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  svc_reads_zero_a: assert property (rd && wdsf_hit(wb_adr_i, OFF_WD_SVC) |-> !wb_dat_o)
    else $error("service reads nonzero");
  wdog_w0_keep_a: assert property (wr && st && !wb_dat_i[0] && wdog_irq |=> wdog_irq [*2])
    else $error("wdog irq lost on zero write");
  wdog_clr_cause_a: assert property ($fell(wdog_irq) |-> $past(wr && st && wb_dat_i[0])
    || $past(wr && st && wb_dat_i[0], 2))
    else $error("wdog irq fell without clear");
  flt_clr_a: assert property (wr && st && wb_dat_i[1] && !fault_valid |=> !fault_irq)
    else $error("fault irq kept after clear");
  flt_fall_a: assert property ($fell(fault_irq) |-> $past(wr && (st
    || wdsf_hit(wb_adr_i, OFF_FLT_IEN))))
    else $error("fault irq fell without cause");
  flt_rise_a: assert property ($rose(fault_irq) |-> $past(fault_valid)
    || $past(wr && wdsf_hit(wb_adr_i, OFF_FLT_IEN) && wb_dat_i[0]))
    else $error("fault irq rose without cause");
  wdog_off_quiet_a: assert property (!armed_r |-> !sys_reset_req && !wdog_irq)
    else $error("watchdog acts before enable");
endmodule // wdsf_props

bind wdsf_top wdsf_props wdsf_props_inst (.mclk(mclk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .fault_valid(fault_valid), .wdog_irq(wdog_irq), .fault_irq(fault_irq),
  .sys_reset_req(sys_reset_req));

/* File: test/wdsf_core_model.sv */
// core bus model: reports faulted accesses as one-cycle strobes
// assumes report is called just after a rising mclk edge
module wdsf_core_model (
  // clock
  input wire logic mclk,
  // fault report
  output logic fault_valid,
  output logic [31:0] fault_addr,
  output logic fault_write,
  output logic [2:0] fault_size,
  output logic fault_cache,
  output logic fault_super,
  output logic fault_data,
  output logic [31:0] fault_wdata
);
  initial {fault_valid, fault_addr, fault_write, fault_size} = '0;
  initial {fault_cache, fault_super, fault_data, fault_wdata} = '0;
  // strobe one cycle, then the lines wander like a released bus
  task automatic report(input logic [31:0] a, input logic w, input logic [31:0] d);
    fault_valid <= 1'b1;
    fault_addr <= a;
    fault_write <= w;
    {fault_size, fault_cache, fault_super, fault_data} <= d[5:0];
    fault_wdata <= d;
    @(posedge mclk);
    fault_valid <= 1'b0;
    fault_addr <= ~a;
    fault_wdata <= ~d;
  endtask
endmodule // wdsf_core_model

/* File: test/wdsf_top_tb.sv */
// self-checking bench of the watchdog service and fault status unit
// assumes wdsf_pkg, wdsf_top, its checker and wdsf_core_model compiled first
module wdsf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdsf_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [31:0] q, fa, fd, dat_o, faddr, fwd;
  logic ack, wirq, firq, rreq, fv, fwr, fcache, fsup, fdata;
  logic [2:0] fsize;
  logic [7:0] bad;
  logic [31:0] flt_q[$];
  int n_errors = 0;
  int checked = 0;
  int n_rst = 0;
  int m_rst = 0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rreq === 1'b1)
      n_rst <= n_rst + 1;
  end
  wdsf_top wdsf_top_inst (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .fault_valid(fv), .fault_addr(faddr), .fault_write(fwr),
    .fault_size(fsize), .fault_cache(fcache), .fault_super(fsup), .fault_data(fdata),
    .fault_wdata(fwd), .wdog_irq(wirq), .fault_irq(firq), .sys_reset_req(rreq));
  wdsf_core_model wdsf_core_model_inst (.mclk(mclk), .fault_valid(fv), .fault_addr(faddr),
    .fault_write(fwr), .fault_size(fsize), .fault_cache(fcache), .fault_super(fsup),
    .fault_data(fdata), .fault_wdata(fwd));
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic give_up;
    n_errors++;
    $display("unexpected at %0t: no answer in time", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (ack === 1'b1)
        break;
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
    if (i == 20)
      give_up();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // nr < 0 waits for the watchdog irq, else for nr reset requests
  task automatic wait_hi(input int nr, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge mclk);
      if (nr < 0 ? wirq === 1'b1 : n_rst >= nr)
        break;
    end
    if (i == lim)
      give_up();
  endtask
  initial begin
    void'($urandom(29954));
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(OFF_WD_SVC, 0);
    bus(1'b1, 8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 0);
    repeat (2) begin
      fa = $urandom();
      fd = $urandom();
      flt_q.push_back(fa);
      wdsf_core_model_inst.report(fa, 1'b1, fd);
      @(posedge mclk);
    end
    rd(OFF_INT_STAT, 2);
    chk(firq, 0);
    bus(1'b1, OFF_FLT_ADDR, ~fa);
    rd(OFF_FLT_ADDR, flt_q[$]);
    rd(OFF_FLT_ATTR, {24'h0, 1'b1, fd[5:3], fd[2], 1'b0, fd[1:0]});
    rd(OFF_FLT_DATA, fd);
    bus(1'b1, OFF_FLT_IEN, 32'hFFFFFFFF);
    chk(firq, 1);
    rd(OFF_FLT_IEN, 1);
    bus(1'b1, OFF_INT_STAT, 32'hFFFFFFFD);
    chk(firq, 1);
    bus(1'b1, OFF_INT_STAT, 32'h2);
    chk(firq, 0);
    rd(OFF_INT_STAT, 0);
    wdsf_core_model_inst.report(32'h1000, 1'b0, 32'h0);
    @(posedge mclk);
    chk(firq, 1);
    rd(OFF_FLT_ADDR, 32'h1000);
    rd(OFF_FLT_ATTR, 0);
    rd(OFF_FLT_DATA, fd);
    bus(1'b1, OFF_FLT_IEN, 32'h0);
    chk(firq, 0);
    bus(1'b1, OFF_INT_STAT, 32'h2);
    bus(1'b1, OFF_FLT_IEN, 32'h1);
    chk(firq, 0);
    bus(1'b1, OFF_WD_CTRL, 32'h85);
    repeat (200) @(posedge mclk);
    chk(wirq, 0);
    wait_hi(-1, 100);
    rd(OFF_INT_STAT, 1);
    bus(1'b1, OFF_WD_SVC, 32'h3C);
    bus(1'b1, OFF_WD_SVC, 32'h55);
    bus(1'b1, OFF_WD_SVC, 32'hAA);
    chk(wirq, 1);
    chk(n_rst, m_rst);
    bus(1'b1, OFF_INT_STAT, 32'h0);
    chk(wirq, 1);
    bus(1'b1, OFF_INT_STAT, 32'h1);
    @(posedge mclk);
    chk(wirq, 0);
    bus(1'b1, OFF_WD_CTRL, 32'hC8);
    repeat (3) begin
      repeat (150) @(posedge mclk);
      bus(1'b1, OFF_WD_SVC, 32'h55);
      rd(OFF_INT_STAT, 0);
      bus(1'b1, OFF_WD_SVC, 32'hAA);
    end
    chk(n_rst, m_rst);
    m_rst++;
    wait_hi(m_rst, 300);
    repeat (2) begin
      repeat (200) @(posedge mclk);
      bus(1'b1, OFF_WD_CTRL, 32'hC8);
    end
    chk(n_rst, m_rst);
    // window mode, service inside the last quarter
    bus(1'b1, OFF_WD_CTRL, 32'hE8);
    repeat (195) @(posedge mclk);
    bus(1'b1, OFF_WD_SVC, 32'h55);
    bus(1'b1, OFF_WD_SVC, 32'hAA);
    chk(n_rst, m_rst);
    bus(1'b1, OFF_WD_CTRL, 32'hE8);
    bus(1'b1, OFF_WD_SVC, 32'h55);
    m_rst++;
    wait_hi(m_rst, 4);
    bus(1'b1, OFF_WD_CTRL, 32'h88);
    bad = 8'($urandom_range(84, 1));
    bus(1'b1, OFF_WD_SVC, {24'h0, bad});
    m_rst++;
    wait_hi(m_rst, 4);
    bus(1'b1, OFF_WD_CTRL, 32'hA8);
    wait_hi(-1, 300);
    chk(n_rst, m_rst);
    m_rst++;
    wait_hi(m_rst, 300);
    // locked and disabled, then a reset in mid-run
    bus(1'b1, OFF_INT_STAT, 32'h1);
    bus(1'b1, OFF_WD_CTRL, 32'h8008);
    bus(1'b1, OFF_WD_CTRL, 32'h85);
    rd(OFF_WD_CTRL, 32'h8008);
    repeat (300) @(posedge mclk);
    chk(wirq, 0);
    chk(n_rst, m_rst);
    resetn <= 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(OFF_WD_CTRL, 0);
    rd(OFF_FLT_IEN, 0);
    repeat (300) @(posedge mclk);
    chk(n_rst, m_rst);
    give_verdict();
  end
endmodule // wdsf_top_tb
